// ---- common/sacr_defines.svh ----
// Purpose: Offsets, field positions and reset values of the synthesizer
//          A configuration register bank.
// Assumes: Register indices are word indices; byte address is index * 4.
// Notes:   Definitions only.
`ifndef SACR_DEFINES_SVH
`define SACR_DEFINES_SVH

// Register indices
`define SACR_IDX_CONTROL_ONE   8'h39
`define SACR_IDX_INT_DIV_HIGH  8'h3a
`define SACR_IDX_INT_DIV_LOW   8'h3b
`define SACR_IDX_FRAC_NUM_TOP  8'h3c
`define SACR_IDX_FRAC_NUM_MID  8'h3d
`define SACR_IDX_FRAC_NUM_LOW  8'h3e
`define SACR_IDX_FRAC_DEN_TOP  8'h3f
`define SACR_IDX_FRAC_DEN_MID  8'h40
`define SACR_IDX_FRAC_DEN_LOW  8'h41
`define SACR_IDX_MOD_CTRL      8'h42
`define SACR_IDX_FILTER_R2     8'h43

// Field positions inside the byte-wide registers
`define SACR_CTL_SPARE_BIT     5
`define SACR_CTL_DOUBLER_BIT   4
`define SACR_CTL_PUMP_HI       3
`define SACR_DITHER_HI         3
`define SACR_DITHER_LO         2
`define SACR_ORDER_HI          1
`define SACR_TOP_HI            5
`define SACR_NIB_HI            3

// Reset values
`define SACR_RST_DOUBLER       1'h1
`define SACR_RST_SPARE         1'h0
`define SACR_RST_PUMP          4'h8
`define SACR_RST_INT_DIV       12'h066
`define SACR_RST_FRAC          22'h000000
`define SACR_RST_DITHER        2'h3
`define SACR_RST_ORDER         2'h0
`define SACR_RST_FILTER        6'h24

// Pump current in 0.1 mA units
`define SACR_PUMP_STEP         7'h04
`define SACR_PUMP_TOP_CODE     4'h8
`define SACR_PUMP_TOP_CURRENT  7'h40
`define SACR_PUMP_LAST_STEP    4'h7
`define SACR_DIV_UNITY         12'h001
`endif

// ---- common/sacr_pkg.sv ----
// Purpose: Types shared by the synthesizer A configuration bank.
// Assumes: Field widths as stored in the register bank.
// Notes:   Constants live in sacr_defines.svh.
package sacr_pkg;
    typedef enum logic [1:0] {
        SACR_DITHER_WEAK, SACR_DITHER_MEDIUM, SACR_DITHER_STRONG,
        SACR_DITHER_OFF
    } sacr_dither_e;

    typedef enum logic [1:0] {
        SACR_ORDER_INTEGER, SACR_ORDER_FIRST, SACR_ORDER_SECOND,
        SACR_ORDER_THIRD
    } sacr_order_e;

    // Full configuration image, also the nonvolatile load format
    typedef struct packed {
        logic ref_doubler_en;
        logic ctrl_spare;
        logic [3:0] synth_a_pump_gain;
        logic [11:0] synth_a_int_divider;
        logic [21:0] synth_a_frac_numerator;
        logic [21:0] synth_a_frac_denominator;
        sacr_dither_e synth_a_dither_sel;
        sacr_order_e synth_a_modulator_order;
        logic [5:0] synth_a_filter_res_code;
    } sacr_cfg_s;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } sacr_apb_req_s;

    // APB answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sacr_apb_rsp_s;
endpackage

// ---- hw/sacr_regs.sv ----
// Purpose: APB register bank holding synthesizer A configuration.
// Assumes: APB master and nonvolatile loader on CLK_IN.
// Notes:   Answers every transfer with one wait-free access cycle.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "sacr_defines.svh"

module sacr_regs (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic CE_IN,
    input sacr_pkg::sacr_apb_req_s APB_IN,
    output sacr_pkg::sacr_apb_rsp_s APB_OUT,
    input wire logic NVM_LOAD_IN,
    input sacr_pkg::sacr_cfg_s NVM_CFG_IN,
    output sacr_pkg::sacr_cfg_s CFG_OUT,
    output logic [11:0] DIV_RATIO_OUT,
    output logic [6:0] PUMP_CURRENT_OUT
);
    import sacr_pkg::*;

    sacr_cfg_s cfg_q;
    sacr_cfg_s cfg_d;
    sacr_apb_rsp_s rsp_q;
    sacr_apb_rsp_s rsp_d;
    logic [11:0] ratio_q;
    logic [11:0] ratio_d;
    logic [6:0] pump_q;
    logic [6:0] pump_d;
    logic [9:0] idx;
    logic hit;
    logic setup;
    logic wr_fire;
    logic [7:0] rd_byte;
    logic [7:0] wb;

    // Word index from byte address; low bits must be zero to hit
    assign idx = APB_IN.paddr[11:2];
    assign setup = APB_IN.psel && !APB_IN.penable;
    assign wr_fire = APB_IN.psel && APB_IN.penable && rsp_q.pready
        && APB_IN.pwrite;
    assign wb = APB_IN.pwdata[7:0];

    // Decode and read mux; reserved bits come back as zero
    always_comb begin
        hit = (APB_IN.paddr[1:0] == 2'h0);
        rd_byte = 8'h00;
        case (idx)
            {2'h0, `SACR_IDX_CONTROL_ONE}: begin
                rd_byte = {2'h0, cfg_q.ctrl_spare, cfg_q.ref_doubler_en,
                    cfg_q.synth_a_pump_gain};
            end
            {2'h0, `SACR_IDX_INT_DIV_HIGH}: begin
                rd_byte = {4'h0, cfg_q.synth_a_int_divider[11:8]};
            end
            {2'h0, `SACR_IDX_INT_DIV_LOW}: begin
                rd_byte = cfg_q.synth_a_int_divider[7:0];
            end
            {2'h0, `SACR_IDX_FRAC_NUM_TOP}: begin
                rd_byte = {2'h0, cfg_q.synth_a_frac_numerator[21:16]};
            end
            {2'h0, `SACR_IDX_FRAC_NUM_MID}: begin
                rd_byte = cfg_q.synth_a_frac_numerator[15:8];
            end
            {2'h0, `SACR_IDX_FRAC_NUM_LOW}: begin
                rd_byte = cfg_q.synth_a_frac_numerator[7:0];
            end
            {2'h0, `SACR_IDX_FRAC_DEN_TOP}: begin
                rd_byte = {2'h0, cfg_q.synth_a_frac_denominator[21:16]};
            end
            {2'h0, `SACR_IDX_FRAC_DEN_MID}: begin
                rd_byte = cfg_q.synth_a_frac_denominator[15:8];
            end
            {2'h0, `SACR_IDX_FRAC_DEN_LOW}: begin
                rd_byte = cfg_q.synth_a_frac_denominator[7:0];
            end
            {2'h0, `SACR_IDX_MOD_CTRL}: begin
                rd_byte = {4'h0, cfg_q.synth_a_dither_sel,
                    cfg_q.synth_a_modulator_order};
            end
            {2'h0, `SACR_IDX_FILTER_R2}: begin
                rd_byte = {2'h0, cfg_q.synth_a_filter_res_code};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Answer prepared in setup so pready stands in the first access cycle
    always_comb begin
        rsp_d = rsp_q;
        rsp_d.pready = 1'b0;
        if (setup) begin
            rsp_d.pready = 1'b1;
            rsp_d.pslverr = !hit;
            rsp_d.prdata = (hit && !APB_IN.pwrite) ? {24'h0, rd_byte}
                : 32'h0;
        end
    end

    // Next configuration: nvm load wins over a write in the same cycle,
    // since the loader only runs at startup before software is active
    always_comb begin
        cfg_d = cfg_q;
        if (NVM_LOAD_IN) begin
            cfg_d = NVM_CFG_IN;
        end else if (wr_fire && hit) begin
            case (idx)
                {2'h0, `SACR_IDX_CONTROL_ONE}: begin
                    cfg_d.ctrl_spare = wb[`SACR_CTL_SPARE_BIT];
                    cfg_d.ref_doubler_en = wb[`SACR_CTL_DOUBLER_BIT];
                    cfg_d.synth_a_pump_gain = wb[`SACR_CTL_PUMP_HI:0];
                end
                {2'h0, `SACR_IDX_INT_DIV_HIGH}: begin
                    cfg_d.synth_a_int_divider[11:8] = wb[`SACR_NIB_HI:0];
                end
                {2'h0, `SACR_IDX_INT_DIV_LOW}: begin
                    cfg_d.synth_a_int_divider[7:0] = wb;
                end
                {2'h0, `SACR_IDX_FRAC_NUM_TOP}: begin
                    cfg_d.synth_a_frac_numerator[21:16] =
                        wb[`SACR_TOP_HI:0];
                end
                {2'h0, `SACR_IDX_FRAC_NUM_MID}: begin
                    cfg_d.synth_a_frac_numerator[15:8] = wb;
                end
                {2'h0, `SACR_IDX_FRAC_NUM_LOW}: begin
                    cfg_d.synth_a_frac_numerator[7:0] = wb;
                end
                {2'h0, `SACR_IDX_FRAC_DEN_TOP}: begin
                    cfg_d.synth_a_frac_denominator[21:16] =
                        wb[`SACR_TOP_HI:0];
                end
                {2'h0, `SACR_IDX_FRAC_DEN_MID}: begin
                    cfg_d.synth_a_frac_denominator[15:8] = wb;
                end
                {2'h0, `SACR_IDX_FRAC_DEN_LOW}: begin
                    cfg_d.synth_a_frac_denominator[7:0] = wb;
                end
                {2'h0, `SACR_IDX_MOD_CTRL}: begin
                    cfg_d.synth_a_dither_sel = sacr_dither_e'(
                        wb[`SACR_DITHER_HI:`SACR_DITHER_LO]);
                    cfg_d.synth_a_modulator_order = sacr_order_e'(
                        wb[`SACR_ORDER_HI:0]);
                end
                {2'h0, `SACR_IDX_FILTER_R2}: begin
                    cfg_d.synth_a_filter_res_code = wb[`SACR_TOP_HI:0];
                end
                default: begin
                    cfg_d = cfg_q;
                end
            endcase
        end
    end

    // Decoded views: effective divide ratio and pump current
    always_comb begin
        ratio_d = cfg_d.synth_a_int_divider;
        if (cfg_d.synth_a_int_divider < 12'h002) begin
            ratio_d = `SACR_DIV_UNITY;
        end
        pump_d = 7'h00;
        if (cfg_d.synth_a_pump_gain == `SACR_PUMP_TOP_CODE) begin
            pump_d = `SACR_PUMP_TOP_CURRENT;
        end else if (cfg_d.synth_a_pump_gain <= `SACR_PUMP_LAST_STEP) begin
            pump_d = 7'({3'h0, cfg_d.synth_a_pump_gain} *
                `SACR_PUMP_STEP);
        end
    end

    // Registers; clock enable freezes everything
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            cfg_q.ref_doubler_en <= `SACR_RST_DOUBLER;
            cfg_q.ctrl_spare <= `SACR_RST_SPARE;
            cfg_q.synth_a_pump_gain <= `SACR_RST_PUMP;
            cfg_q.synth_a_int_divider <= `SACR_RST_INT_DIV;
            cfg_q.synth_a_frac_numerator <= `SACR_RST_FRAC;
            cfg_q.synth_a_frac_denominator <= `SACR_RST_FRAC;
            cfg_q.synth_a_dither_sel <= SACR_DITHER_OFF;
            cfg_q.synth_a_modulator_order <= SACR_ORDER_INTEGER;
            cfg_q.synth_a_filter_res_code <= `SACR_RST_FILTER;
            rsp_q <= '0;
            ratio_q <= `SACR_RST_INT_DIV;
            pump_q <= `SACR_PUMP_TOP_CURRENT;
        end else if (CE_IN) begin
            cfg_q <= cfg_d;
            rsp_q <= rsp_d;
            ratio_q <= ratio_d;
            pump_q <= pump_d;
        end
    end

    assign APB_OUT = rsp_q;
    assign CFG_OUT = cfg_q;
    assign DIV_RATIO_OUT = ratio_q;
    assign PUMP_CURRENT_OUT = pump_q;

    // Checks
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RST_IN);

    doubler_write_a: assert property (
        CE_IN && !NVM_LOAD_IN && wr_fire
        && APB_IN.paddr == {`SACR_IDX_CONTROL_ONE, 2'h0}
        |=> cfg_q.ref_doubler_en == $past(APB_IN.pwdata[4]))
        else $error("doubler bit not written");
    // Decoded views land on the same edge as the field they decode
    pump_current_a: assert property (
        cfg_q.synth_a_pump_gain == `SACR_PUMP_TOP_CODE
        |-> PUMP_CURRENT_OUT == `SACR_PUMP_TOP_CURRENT)
        else $error("pump code 8 not 6.4 mA");
    div_unity_a: assert property (
        cfg_q.synth_a_int_divider < 12'h002
        |-> DIV_RATIO_OUT == `SACR_DIV_UNITY)
        else $error("divider 0 or 1 not unity");
    div_low_a: assert property (
        CE_IN && !NVM_LOAD_IN && wr_fire
        && APB_IN.paddr == {`SACR_IDX_INT_DIV_LOW, 2'h0}
        |=> cfg_q.synth_a_int_divider[7:0] == $past(APB_IN.pwdata[7:0])
        && $stable(cfg_q.synth_a_int_divider[11:8]))
        else $error("divider low byte write wrong");
    num_top_a: assert property (
        CE_IN && !NVM_LOAD_IN && wr_fire
        && APB_IN.paddr == {`SACR_IDX_FRAC_NUM_TOP, 2'h0}
        |=> cfg_q.synth_a_frac_numerator[21:16]
        == $past(APB_IN.pwdata[5:0]))
        else $error("numerator top write wrong");
    den_top_a: assert property (
        CE_IN && !NVM_LOAD_IN && wr_fire
        && APB_IN.paddr == {`SACR_IDX_FRAC_DEN_TOP, 2'h0}
        |=> cfg_q.synth_a_frac_denominator[21:16]
        == $past(APB_IN.pwdata[5:0]))
        else $error("denominator top write wrong");
    mod_ctrl_a: assert property (
        CE_IN && !NVM_LOAD_IN && wr_fire
        && APB_IN.paddr == {`SACR_IDX_MOD_CTRL, 2'h0}
        |=> cfg_q.synth_a_dither_sel == $past(APB_IN.pwdata[3:2])
        && cfg_q.synth_a_modulator_order == $past(APB_IN.pwdata[1:0]))
        else $error("modulator control write wrong");
    reserved_zero_a: assert property (
        CE_IN && setup && !APB_IN.pwrite
        && (idx == {2'h0, `SACR_IDX_INT_DIV_HIGH}
        || idx == {2'h0, `SACR_IDX_MOD_CTRL})
        |=> APB_OUT.pready && APB_OUT.prdata[31:4] == 28'h0)
        else $error("reserved bits read nonzero");
    ready_once_a: assert property (
        CE_IN && APB_OUT.pready |=> !APB_OUT.pready)
        else $error("pready held two cycles");
    filter_load_a: assert property (
        CE_IN && NVM_LOAD_IN
        |=> cfg_q.synth_a_filter_res_code
        == $past(NVM_CFG_IN.synth_a_filter_res_code))
        else $error("filter code not loaded");
    // Write guards; all but refused_a and load_wins_a need the load idle since a load beats a write
    pump_write_a: assert property (
        CE_IN && !NVM_LOAD_IN && wr_fire
        && APB_IN.paddr == {`SACR_IDX_CONTROL_ONE, 2'h0}
        |=> cfg_q.synth_a_pump_gain == $past(APB_IN.pwdata[3:0]))
        else $error("pump gain not written");
    div_high_a: assert property (
        CE_IN && !NVM_LOAD_IN && wr_fire
        && APB_IN.paddr == {`SACR_IDX_INT_DIV_HIGH, 2'h0}
        |=> cfg_q.synth_a_int_divider[11:8] == $past(APB_IN.pwdata[3:0])
        && $stable(cfg_q.synth_a_int_divider[7:0]))
        else $error("divider high nibble write wrong");
    filter_write_a: assert property (
        CE_IN && !NVM_LOAD_IN && wr_fire
        && APB_IN.paddr == {`SACR_IDX_FILTER_R2, 2'h0}
        |=> cfg_q.synth_a_filter_res_code == $past(APB_IN.pwdata[5:0]))
        else $error("filter code not written");
    refused_a: assert property (
        CE_IN && setup && !hit
        |=> APB_OUT.pready && APB_OUT.pslverr && APB_OUT.prdata == 32'h0)
        else $error("unmapped access not refused");
    refused_write_a: assert property (
        CE_IN && !NVM_LOAD_IN && wr_fire && !hit |=> $stable(cfg_q))
        else $error("refused write changed the bank");
    load_wins_a: assert property (
        CE_IN && NVM_LOAD_IN && wr_fire |=> cfg_q == $past(NVM_CFG_IN))
        else $error("write beat the nonvolatile load");
    // Enable low must hold the answer too, or a stalled master misreads
    frozen_a: assert property (
        !CE_IN |=> $stable(cfg_q) && $stable(rsp_q))
        else $error("state moved with clock enable low");

    // Main scenarios worth seeing at least once
    write_seen_c: cover property (wr_fire && hit);
    unmapped_c: cover property (APB_OUT.pready && APB_OUT.pslverr);
    nvm_load_c: cover property (CE_IN && NVM_LOAD_IN);
    refused_write_c: cover property (CE_IN && wr_fire && !hit);
    frozen_c: cover property (!CE_IN && NVM_LOAD_IN);
endmodule

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the synthesizer A register bank.
// Assumes: One access cycle per APB transfer; byte address is index * 4.
// Notes:   Every scenario is a task that drives and judges by itself.
`timescale 1ns/1ps
`include "sacr_defines.svh"

module tb_top;
    import sacr_pkg::*;

    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic nvm_load_in = 1'b0;
    sacr_apb_req_s apb_in = '0;
    sacr_apb_rsp_s apb_out;
    sacr_cfg_s nvm_cfg_in = '0;
    sacr_cfg_s cfg_out;
    logic [11:0] div_ratio_out;
    logic [6:0] pump_current_out;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;
    // Register order follows the index map
    logic [7:0] idx_tab [11] = '{`SACR_IDX_CONTROL_ONE,
        `SACR_IDX_INT_DIV_HIGH, `SACR_IDX_INT_DIV_LOW, `SACR_IDX_FRAC_NUM_TOP,
        `SACR_IDX_FRAC_NUM_MID, `SACR_IDX_FRAC_NUM_LOW, `SACR_IDX_FRAC_DEN_TOP,
        `SACR_IDX_FRAC_DEN_MID, `SACR_IDX_FRAC_DEN_LOW, `SACR_IDX_MOD_CTRL,
        `SACR_IDX_FILTER_R2};
    logic [7:0] rst_tab [11] = '{8'h18, 8'h00, 8'h66, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h0c, 8'h24};
    // Patterns set every reserved bit so dropped writes show up
    logic [7:0] pat_tab [11] = '{8'he5, 8'hfa, 8'h5c, 8'heb, 8'h71, 8'hc4,
        8'hd3, 8'h8e, 8'h07, 8'hf9, 8'hf0};
    logic [7:0] msk_tab [11] = '{8'h3f, 8'h0f, 8'hff, 8'h3f, 8'hff, 8'hff,
        8'h3f, 8'hff, 8'hff, 8'h0f, 8'h3f};

    sacr_regs sacr_regs_inst (
        .CLK_IN(clk_in),
        .RST_IN(rst_in),
        .CE_IN(ce_in),
        .APB_IN(apb_in),
        .APB_OUT(apb_out),
        .NVM_LOAD_IN(nvm_load_in),
        .NVM_CFG_IN(nvm_cfg_in),
        .CFG_OUT(cfg_out),
        .DIV_RATIO_OUT(div_ratio_out),
        .PUMP_CURRENT_OUT(pump_current_out)
    );

    // 250 MHz clock
    always #2 clk_in = ~clk_in;

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Whole run needs a few hundred cycles; this ceiling is generous
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            $display("BAD %0t run timed out", $time);
            wrap_up();
        end
    end

    task automatic chk(input logic [127:0] got, input logic [127:0] exp,
                       input string msg);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s: got %0h want %0h", $time, msg, got, exp);
        end
    endtask

    function automatic logic [11:0] adr(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction

    // Request held until pready is sampled high; data taken at that edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_in);
        apb_in.psel <= 1'b1;
        apb_in.penable <= 1'b0;
        apb_in.pwrite <= wr;
        apb_in.paddr <= a;
        apb_in.pwdata <= wd;
        @(posedge clk_in);
        apb_in.penable <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (apb_out.pready !== 1'b1);
        chk(n, 1, "access cycles");
        rd = apb_out.prdata;
        err = apb_out.pslverr;
        apb_in.psel <= 1'b0;
        apb_in.penable <= 1'b0;
    endtask

    task automatic t_reset();
        for (int i = 0; i < 11; i++) begin
            apb(1'b0, adr(idx_tab[i]), 32'h0);
            chk(rd, {24'h0, rst_tab[i]}, "rst");
            chk(err, 0, "reset read error");
        end
        chk(cfg_out.ref_doubler_en, 1, "doubler default");
        chk(pump_current_out, 7'h40, "pump default");
        chk(div_ratio_out, 12'h066, "ratio default");
    endtask

    task automatic t_pattern();
        for (int i = 0; i < 11; i++) begin
            apb(1'b1, adr(idx_tab[i]), {24'hffffff, pat_tab[i]});
        end
        for (int i = 0; i < 11; i++) begin
            apb(1'b0, adr(idx_tab[i]), 32'h0);
            chk(rd, {24'h0, pat_tab[i] & msk_tab[i]}, "masked read");
        end
        chk(cfg_out.ref_doubler_en, 0, "doubler off");
        chk(cfg_out.synth_a_int_divider, 12'ha5c, "divider join");
        chk(cfg_out.synth_a_frac_numerator, 22'h2b71c4, "num join");
        chk(cfg_out.synth_a_frac_denominator, 22'h138e07, "den join");
        chk(cfg_out.synth_a_dither_sel, 2'h2, "dither field");
        chk(cfg_out.synth_a_modulator_order, 2'h1, "order field");
        chk(cfg_out.synth_a_filter_res_code, 6'h30, "filter field");
    endtask

    task automatic t_pump();
        // Codes above 8 decode to no current
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, adr(`SACR_IDX_CONTROL_ONE), 32'h10 | c);
            @(negedge clk_in);
            chk(pump_current_out, (c == 8) ? 64 : (c < 8) ? c * 4 : 0,
                "pump current");
            chk(cfg_out.synth_a_pump_gain, c, "pump code");
        end
    endtask

    task automatic t_div();
        logic [11:0] codes [5] = '{12'h000, 12'h001, 12'h002, 12'hfff,
            12'h800};
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, adr(`SACR_IDX_INT_DIV_HIGH), {28'h0, codes[i][11:8]});
            apb(1'b1, adr(`SACR_IDX_INT_DIV_LOW), {24'h0, codes[i][7:0]});
            @(negedge clk_in);
            chk(div_ratio_out, (codes[i] < 2) ? 1 : codes[i], "ratio");
        end
    endtask

    task automatic t_modes();
        for (int m = 0; m < 16; m++) begin
            apb(1'b1, adr(`SACR_IDX_MOD_CTRL), m);
            @(negedge clk_in);
            chk(cfg_out.synth_a_dither_sel, m >> 2, "dither code");
            chk(cfg_out.synth_a_modulator_order, m & 3, "order code");
        end
    endtask

    // Filter codes, then refused accesses leave it alone
    task automatic t_filter_err();
        apb(1'b1, adr(`SACR_IDX_FILTER_R2), 32'h01);
        apb(1'b0, adr(`SACR_IDX_FILTER_R2), 32'h0);
        chk(rd, 32'h01, "filter low code");
        apb(1'b1, adr(`SACR_IDX_FILTER_R2), 32'h30);
        apb(1'b0, adr(8'h44), 32'h0);
        chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
        apb(1'b1, adr(`SACR_IDX_FILTER_R2) + 12'h1, 32'h05);
        chk(err, 1, "misaligned write");
        apb(1'b0, adr(`SACR_IDX_FILTER_R2), 32'h0);
        chk(rd, 32'h30, "filter kept");
    endtask

    // Enable low freezes the bank even against a load
    task automatic t_ce();
        sacr_cfg_s keep;
        @(posedge clk_in);
        keep = cfg_out;
        ce_in <= 1'b0;
        nvm_load_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk(cfg_out, keep, "frozen by enable");
        ce_in <= 1'b1;
        nvm_load_in <= 1'b0;
        @(negedge clk_in);
        chk(cfg_out, keep, "no load after enable");
    endtask

    // Image replaces the whole bank and beats a write in the same cycle;
    // the load stands through the access phase so it meets the write edge
    task automatic t_nvm();
        @(posedge clk_in);
        nvm_cfg_in <= '{1'b1, 1'b0, 4'h3, 12'h066, 22'h0a0b0c, 22'h010203,
            SACR_DITHER_OFF, SACR_ORDER_THIRD, 6'h24};
        apb_in.psel <= 1'b1;
        apb_in.pwrite <= 1'b1;
        apb_in.paddr <= adr(`SACR_IDX_FILTER_R2);
        apb_in.pwdata <= 32'h11;
        @(posedge clk_in);
        apb_in.penable <= 1'b1;
        nvm_load_in <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (apb_out.pready !== 1'b1);
        apb_in.psel <= 1'b0;
        apb_in.penable <= 1'b0;
        nvm_load_in <= 1'b0;
        @(negedge clk_in);
        chk(cfg_out, nvm_cfg_in, "loaded image");
        chk(pump_current_out, 7'h0c, "loaded pump");
        apb(1'b0, adr(`SACR_IDX_INT_DIV_LOW), 32'h0);
        chk(rd, 32'h66, "restored low byte");
    endtask

    // Reset in mid-run brings every default back
    task automatic t_rerst();
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
    endtask

    initial begin
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_pattern();
        t_pump();
        t_div();
        t_modes();
        t_filter_err();
        t_ce();
        t_nvm();
        t_rerst();
        wrap_up();
    end
endmodule
